// >>> logic/bam_trigger_match.sv
// Bus attribute comparator for the debug breakpoint trigger
//
// Notes on behaviour
// - A set direction mask makes the read/write attribute always match.
// - Each set size mask bit drops that size bit from the compare.
// - Each set type mask bit drops that type bit from the compare.
// - Each set modifier mask bit drops that modifier bit from the compare.
// - The programmed direction is compared with the bus read/write signal.
// - Size codes are longword 00, byte 01, word 10, with 11 reserved.
// - Type codes are normal 00, external/DMA 01, emulator 10, ack/CPU space 11.
// - Debug port memory commands take their type from the type field.
// - The type field selects how the modifier field is read.
// - The modifier field is compared with the bus modifier signals.
// - Debug port memory commands take their modifier from the field.
// - Type 00 and 10 modifier codes decode as listed, others reserved.
// - Type 11 modifier 000 is CPU space, 001 to 111 are ack levels.
// - The match feeds the trigger only when the trigger setup selects it.
// - The pattern is written by the CPU as register 6 or by the debugger.
`timescale 1ns/1ps
module bam_trigger_match
    import bam_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cpu_wr,
    input wire logic cpu_wr_inhibit,
    input wire logic dbg_wr,
    input wire logic [4:0] reg_index,
    input wire logic [31:0] wr_data,
    input wire logic bus_valid,
    input wire bam_attr_s bus_attr,
    input wire logic attr_select,
    output logic attr_match,
    output logic attr_trigger,
    output logic [1:0] cmd_ttype,
    output logic [2:0] cmd_tmod,
    output bam_class_e cmd_class,
    output logic [2:0] cmd_ack_level,
    output logic size_reserved
);
    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        bam_pattern_s pattern;
        logic match;
        logic trigger;
    } bam_state_s;

    bam_state_s state;
    bam_state_s next_state;
    logic wr_hit;
    logic [7:0] care;
    logic [7:0] diff;

    // Either writer lands on the same register; the debugger wins the
    // inhibit since the processor lock only applies to the CPU path.
    assign wr_hit = (reg_index == BAM_REG_INDEX)
        && (dbg_wr || (cpu_wr && !cpu_wr_inhibit));

    // Bits that take part in the compare: masks clear the care bit
    assign care = ~{state.pattern.direction_mask,
                    state.pattern.size_mask,
                    state.pattern.transfer_type_mask,
                    state.pattern.transfer_modifier_mask};
    // Direction, size, type and modifier compared bit for bit
    assign diff = state.pattern.value ^ bus_attr;

    // ========================================================
    // Next state
    // ========================================================
    always_comb
    begin
        next_state = state;
        if (wr_hit)
            next_state.pattern = bam_pattern_s'(wr_data[15:0]);
        // Registered compare keeps the bus timing path short
        next_state.match = bus_valid && ((diff & care) == 8'h00);
        next_state.trigger = next_state.match && attr_select;
    end

    // ========================================================
    // Registers
    // ========================================================
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state.pattern <= bam_pattern_s'(BAM_RESET_VALUE[15:0]);
            state.match <= 1'b0;
            state.trigger <= 1'b0;
        end
        else
            state <= next_state;
    end

    // ========================================================
    // Outputs
    // ========================================================
    assign attr_match = state.match;
    assign attr_trigger = state.trigger;
    // Attributes lent to debug port memory commands
    assign cmd_ttype = state.pattern.value.ttype;
    assign cmd_tmod = state.pattern.value.tmod;
    assign size_reserved = (state.pattern.value.size == BAM_SIZE_RSVD);

    bam_attr_decode u_decode (
        .ttype(state.pattern.value.ttype),
        .tmod(state.pattern.value.tmod),
        .access_class(cmd_class),
        .ack_level(cmd_ack_level)
    );

    // ========================================================
    // Assertions
    // ========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Attempts cut short by a reset are dropped, not failed

    a_dir_mask_ignores: assert property (
        (state.pattern.direction_mask && bus_valid
         && ((diff[6:0] & care[6:0]) == 7'h00)) |=> attr_match)
        else $error("Direction mask did not hide the direction bit");
    a_size_compared: assert property (
        (bus_valid && !state.pattern.size_mask[0] && diff[5]) |=> !attr_match)
        else $error("Unmasked size bit mismatch still matched");
    a_type_compared: assert property (
        (bus_valid && !state.pattern.transfer_type_mask[1] && diff[4])
        |=> !attr_match)
        else $error("Unmasked type bit mismatch still matched");
    a_mod_compared: assert property (
        (bus_valid && !state.pattern.transfer_modifier_mask[2] && diff[2])
        |=> !attr_match)
        else $error("Unmasked modifier bit mismatch still matched");
    a_dir_compared: assert property (
        (bus_valid && !state.pattern.direction_mask
         && (bus_attr.dir != state.pattern.value.dir)) |=> !attr_match)
        else $error("Direction mismatch still matched");
    a_idle_no_match: assert property (
        !bus_valid |=> !attr_match)
        else $error("Match without a bus transfer");
    a_trigger_gated: assert property (
        attr_trigger |-> (attr_match && $past(attr_select)))
        else $error("Trigger without selection");
    a_write_loads: assert property (
        wr_hit |=> (cmd_ttype == $past(wr_data[4:3])
                    && cmd_tmod == $past(wr_data[2:0])))
        else $error("Register write did not load the pattern");
    a_cpu_locked: assert property (
        (cpu_wr && cpu_wr_inhibit && !dbg_wr) |=> $stable(state.pattern))
        else $error("Inhibited processor write changed the pattern");
    a_ack_level: assert property (
        (cmd_class == BAM_CLS_INT_ACK) |-> (cmd_ack_level == cmd_tmod))
        else $error("Acknowledge level differs from modifier");
    // Exact equality must be seen too, not only mismatches refused
    a_full_match: assert property (
        (bus_valid && ((diff & care) == 8'h00)) |=> attr_match)
        else $error("Equal attributes did not match");
    // Trigger stays low whenever the setup leaves attributes out
    a_trigger_off: assert property (
        !attr_select |=> !attr_trigger)
        else $error("Trigger rose while not selected");

    // ========================================================
    // Per-bit compare checks
    // ========================================================
    // Two checks per attribute bit, so a slip in the mask layout
    // points at the very bit that went wrong
    for (genvar g = 0; g < 8; g++)
    begin : g_bit_chk
        a_bit_blocks: assert property (
            (bus_valid && care[g] && diff[g]) |=> !attr_match)
            else $error("Unmasked bit mismatch still matched");
        a_mask_hides: assert property (
            (bus_valid && !care[g] && diff[g]
             && ((diff & care) == 8'h00)) |=> attr_match)
            else $error("Masked bit mismatch blocked the match");
    end

    // ========================================================
    // Register write checks
    // ========================================================
    // The debugger path must land even while the processor is locked
    a_dbg_loads: assert property (
        (dbg_wr && (reg_index == BAM_REG_INDEX))
        |=> (state.pattern == $past(wr_data[15:0])))
        else $error("Debugger write did not load the pattern");
    // Other indexes belong to neighbouring registers
    a_index_other: assert property (
        (reg_index != BAM_REG_INDEX) |=> $stable(state.pattern))
        else $error("Write to another register changed the pattern");

    // ========================================================
    // Decode checks
    // ========================================================
    // Decode is combinational, so these hold in the same cycle
    a_ext_dma: assert property (
        (cmd_ttype == BAM_TYPE_EXT_DMA) |-> (cmd_class == BAM_CLS_EXT_DMA))
        else $error("Type 01 did not read as an external access");
    // Acknowledge space with modifier zero is plain CPU space
    a_cpu_space: assert property (
        (cmd_ttype == BAM_TYPE_ACK && cmd_tmod == 3'h0)
        |-> (cmd_class == BAM_CLS_CPU_SPACE))
        else $error("Type 11 modifier 0 did not read as CPU space");
    // Emulator space has only two legal modifiers
    a_emu_valid: assert property (
        (cmd_ttype == BAM_TYPE_EMU && cmd_class != BAM_CLS_RESERVED)
        |-> (cmd_tmod == BAM_MOD_SUPV_DATA
             || cmd_tmod == BAM_MOD_SUPV_CODE))
        else $error("Emulator type decoded a reserved modifier");

    // ========================================================
    // Coverage of the main scenarios
    // ========================================================
    // Covers only say that a scenario was reached
    c_match: cover property (bus_valid ##1 attr_match);
    c_trigger: cover property (attr_trigger);
    c_dbg_write: cover property (dbg_wr && wr_hit);
    c_ext_dma: cover property (cmd_class == BAM_CLS_EXT_DMA);
    c_int_ack: cover property (cmd_class == BAM_CLS_INT_ACK);
endmodule : bam_trigger_match

// >>> logic/bam_pkg.sv
// Package for the bus attribute trigger match block
package bam_pkg;
    // ========================================================
    // Register access
    // ========================================================
    localparam logic [4:0] BAM_REG_INDEX = 5'h06;
    localparam logic [31:0] BAM_RESET_VALUE = 32'h0000_0005;
    // ========================================================
    // Field positions
    // ========================================================
    localparam int BAM_DIR_MASK_BIT = 15;
    localparam int BAM_SIZE_MASK_LSB = 13;
    localparam int BAM_TYPE_MASK_LSB = 11;
    localparam int BAM_MOD_MASK_LSB = 8;
    localparam int BAM_DIR_BIT = 7;
    localparam int BAM_SIZE_LSB = 5;
    localparam int BAM_TYPE_LSB = 3;
    localparam int BAM_MOD_LSB = 0;
    // ========================================================
    // Encodings
    // ========================================================
    localparam logic [1:0] BAM_SIZE_LONG = 2'h0;
    localparam logic [1:0] BAM_SIZE_BYTE = 2'h1;
    localparam logic [1:0] BAM_SIZE_WORD = 2'h2;
    localparam logic [1:0] BAM_SIZE_RSVD = 2'h3;
    localparam logic [1:0] BAM_TYPE_NORMAL = 2'h0;
    localparam logic [1:0] BAM_TYPE_EXT_DMA = 2'h1;
    localparam logic [1:0] BAM_TYPE_EMU = 2'h2;
    localparam logic [1:0] BAM_TYPE_ACK = 2'h3;
    localparam logic [2:0] BAM_MOD_PUSH = 3'h0;
    localparam logic [2:0] BAM_MOD_USER_DATA = 3'h1;
    localparam logic [2:0] BAM_MOD_USER_CODE = 3'h2;
    localparam logic [2:0] BAM_MOD_SUPV_DATA = 3'h5;
    localparam logic [2:0] BAM_MOD_SUPV_CODE = 3'h6;

    // One set of transfer attributes
    typedef struct packed {
        logic dir;
        logic [1:0] size;
        logic [1:0] ttype;
        logic [2:0] tmod;
    } bam_attr_s;

    // Register fields, bits 15..0
    typedef struct packed {
        logic direction_mask;
        logic [1:0] size_mask;
        logic [1:0] transfer_type_mask;
        logic [2:0] transfer_modifier_mask;
        bam_attr_s value;
    } bam_pattern_s;

    // Meaning of the programmed type and modifier pair
    typedef enum logic [3:0] {
        BAM_CLS_RESERVED = 4'b0000,
        BAM_CLS_PUSH = 4'b0001,
        BAM_CLS_USER_DATA = 4'b0010,
        BAM_CLS_USER_CODE = 4'b0011,
        BAM_CLS_SUPV_DATA = 4'b0100,
        BAM_CLS_SUPV_CODE = 4'b0101,
        BAM_CLS_EMU_DATA = 4'b0110,
        BAM_CLS_EMU_CODE = 4'b0111,
        BAM_CLS_CPU_SPACE = 4'b1000,
        BAM_CLS_INT_ACK = 4'b1001,
        BAM_CLS_EXT_DMA = 4'b1010
    } bam_class_e;
endpackage : bam_pkg

// >>> logic/bam_attr_decode.sv
// Decoder of the programmed type and modifier into an access class
`timescale 1ns/1ps
module bam_attr_decode
    import bam_pkg::*;
(
    input wire logic [1:0] ttype,
    input wire logic [2:0] tmod,
    output bam_class_e access_class,
    output logic [2:0] ack_level
);
    // ========================================================
    // Type selects how the modifier reads
    // ========================================================
    always_comb
    begin
        access_class = BAM_CLS_RESERVED;
        ack_level = 3'h0;
        case (ttype)
            BAM_TYPE_NORMAL:
            begin
                case (tmod)
                    BAM_MOD_PUSH: access_class = BAM_CLS_PUSH;
                    BAM_MOD_USER_DATA: access_class = BAM_CLS_USER_DATA;
                    BAM_MOD_USER_CODE: access_class = BAM_CLS_USER_CODE;
                    BAM_MOD_SUPV_DATA: access_class = BAM_CLS_SUPV_DATA;
                    BAM_MOD_SUPV_CODE: access_class = BAM_CLS_SUPV_CODE;
                    default: access_class = BAM_CLS_RESERVED;
                endcase
            end
            BAM_TYPE_EMU:
            begin
                case (tmod)
                    BAM_MOD_SUPV_DATA: access_class = BAM_CLS_EMU_DATA;
                    BAM_MOD_SUPV_CODE: access_class = BAM_CLS_EMU_CODE;
                    default: access_class = BAM_CLS_RESERVED;
                endcase
            end
            BAM_TYPE_ACK:
            begin
                // Modifier 0 is CPU space, others give the level
                if (tmod == 3'h0)
                    access_class = BAM_CLS_CPU_SPACE;
                else
                begin
                    access_class = BAM_CLS_INT_ACK;
                    ack_level = tmod;
                end
            end
            // Only meaningful for debug port memory commands
            BAM_TYPE_EXT_DMA: access_class = BAM_CLS_EXT_DMA;
            default: access_class = BAM_CLS_RESERVED;
        endcase
    end
endmodule : bam_attr_decode

// >>> sim/bam_bus_model.sv
// Local bus attribute source that faces the trigger comparator
`timescale 1ns/1ps
module bam_bus_model
    import bam_pkg::*;
(
    input wire logic clk_sys,
    input wire logic req,
    input wire bam_attr_s req_attr,
    output logic bus_valid,
    output bam_attr_s bus_attr
);
    bam_attr_s idle_pat = bam_attr_s'(8'h5a);
    // Idle lines toggle so a stale attribute can never pose as live
    always @(posedge clk_sys)
    begin
        idle_pat <= ~idle_pat;
    end
    // Live transfer carries direction, size, type and modifier together
    assign bus_valid = req;
    assign bus_attr = req ? req_attr : idle_pat;
endmodule : bam_bus_model

// >>> sim/testbench.sv
// Self-checking bench for the bus attribute trigger comparator
`timescale 1ns/1ps
module testbench
    import bam_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic cpu_wr = 1'b0;
    logic cpu_wr_inhibit = 1'b0;
    logic dbg_wr = 1'b0;
    logic [4:0] reg_index = 5'h00;
    logic [31:0] wr_data = 32'h0;
    logic req = 1'b0;
    logic attr_select = 1'b0;
    bam_attr_s req_attr = '0;
    bam_attr_s bus_attr;
    bam_class_e cmd_class;
    logic bus_valid, attr_match, attr_trigger, size_reserved;
    logic [1:0] cmd_ttype;
    logic [2:0] cmd_tmod, cmd_ack_level;
    logic [15:0] pat = 16'h0005;
    logic [31:0] seed = 32'h24;
    logic [31:0] r;
    logic [1:0] got_e;
    logic [1:0] expq[$];
    int errors = 0;
    int num_checks = 0;
    // ========================================================
    // Clock, design and bus source
    // ========================================================
    always #5 clk_sys = ~clk_sys;
    bam_trigger_match DUT (.clk_sys(clk_sys), .arst_n(arst_n),
        .cpu_wr(cpu_wr), .cpu_wr_inhibit(cpu_wr_inhibit), .dbg_wr(dbg_wr),
        .reg_index(reg_index), .wr_data(wr_data), .bus_valid(bus_valid),
        .bus_attr(bus_attr), .attr_select(attr_select),
        .attr_match(attr_match), .attr_trigger(attr_trigger),
        .cmd_ttype(cmd_ttype), .cmd_tmod(cmd_tmod), .cmd_class(cmd_class),
        .cmd_ack_level(cmd_ack_level), .size_reserved(size_reserved));
    bam_bus_model model (.clk_sys(clk_sys), .req(req),
        .req_attr(req_attr), .bus_valid(bus_valid), .bus_attr(bus_attr));
    // ========================================================
    // Helpers
    // ========================================================
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Masks line up bit for bit with the value half of the pattern
    function logic hit(input logic [7:0] a);
        return ((pat[7:0] ^ a) & ~pat[15:8]) == 8'h00;
    endfunction : hit
    function bam_class_e cls(input logic [1:0] t, input logic [2:0] m);
        case (t)
            2'h0: return m == 3'h0 ? BAM_CLS_PUSH : m == 3'h1 ?
                BAM_CLS_USER_DATA : m == 3'h2 ? BAM_CLS_USER_CODE :
                m == 3'h5 ? BAM_CLS_SUPV_DATA : m == 3'h6 ?
                BAM_CLS_SUPV_CODE : BAM_CLS_RESERVED;
            2'h1: return BAM_CLS_EXT_DMA;
            2'h2: return m == 3'h5 ? BAM_CLS_EMU_DATA : m == 3'h6 ?
                BAM_CLS_EMU_CODE : BAM_CLS_RESERVED;
            default: return m == 3'h0 ? BAM_CLS_CPU_SPACE : BAM_CLS_INT_ACK;
        endcase
    endfunction : cls
    // One bus cycle; the expected outcome is queued for the watcher
    task cyc(input logic v, input logic [7:0] a, input logic sel);
        @(negedge clk_sys);
        {cpu_wr, dbg_wr} = 2'b00;
        req = v;
        req_attr = bam_attr_s'(a);
        attr_select = sel;
        expq.push_back({v & hit(a), v & hit(a) & sel});
    endtask : cyc
    task chk_cmd();
        check(32'(cmd_ttype), 32'(pat[4:3]));
        check(32'(cmd_tmod), 32'(pat[2:0]));
        check(32'(cmd_class), 32'(cls(pat[4:3], pat[2:0])));
        check(32'(cmd_ack_level), 32'(&pat[4:3] ? pat[2:0] : 3'h0));
        check(32'(size_reserved), 32'(pat[6:5] == 2'h3));
    endtask : chk_cmd
    task wr(input logic cpu, input logic inh, input logic [4:0] idx,
        input logic [15:0] d);
        @(negedge clk_sys);
        req = 1'b0;
        {cpu_wr, dbg_wr, cpu_wr_inhibit, reg_index} = {cpu, !cpu, inh, idx};
        wr_data = {16'(xs() >> 16), d};
        expq.push_back(2'b00);
        if (idx == 5'h06 && !(cpu && inh)) pat = d;
        cyc(1'b0, 8'h00, 1'b0);
        chk_cmd();
    endtask : wr
    task close_out();
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    // Watcher: every queued outcome is compared one edge after its cycle
    always @(posedge clk_sys)
    begin
        #1;
        if (expq.size() != 0)
        begin
            got_e = expq.pop_front();
            check(32'({attr_match, attr_trigger}),
                32'(got_e));
        end
    end
    // ========================================================
    // Scenarios
    // ========================================================
    initial
    begin
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        chk_cmd();
        for (int i = 0; i < 128; i++)
        begin
            wr(1'b0, 1'b0, 5'h06, 16'(i));
            cyc(1'b1, pat[7:0], i[0]);
            cyc(1'b1, pat[7:0] ^ 8'(1 << (i % 8)), 1'b1);
        end
        for (int k = 0; k < 8; k++)
        begin
            wr(1'b0, 1'b0, 5'h06, 16'(xs()) & 16'h00ff | 16'(1 << (k + 8)));
            cyc(1'b1, pat[7:0] ^ 8'(1 << k), 1'b1);
            cyc(1'b1, pat[7:0] ^ 8'(1 << ((k + 1) % 8)), 1'b1);
        end
        wr(1'b1, 1'b1, 5'h06, 16'hffff);
        wr(1'b1, 1'b0, 5'h07, 16'hffff);
        wr(1'b0, 1'b1, 5'h06, 16'h00f3);
        wr(1'b1, 1'b0, 5'h06, 16'h8a6b);
        for (int n = 0; n < 400; n++)
        begin
            r = xs();
            if (n % 25 == 0) wr(1'b0, 1'b0, 5'h06, r[31:16]);
            cyc(r[0] | r[1], pat[7:0] ^ (r[15:8] & (r[2] ? pat[15:8] : 8'hff)),
                r[3]);
            if (n == 200)
            begin
                @(negedge clk_sys);
                {arst_n, req} = 2'b00;
                pat = 16'h0005;
                expq.push_back(2'b00);
                @(negedge clk_sys);
                arst_n = 1'b1;
                chk_cmd();
            end
        end
        repeat (3) @(negedge clk_sys);
        close_out();
    end
    // Cuts a hang short
    initial
    begin
        #100000;
        errors++;
        close_out();
    end
endmodule : testbench
